/* design/cpt_capture_timer.v */
// capture timer: 16-bit counter with capture/compare, avalon-mm registers
// assumes event_in comes from another domain; companion tick is a same-clock pulse
`timescale 1ns/1ps
`include "cpt_defines.vh"

module cpt_capture_timer (
  input  wire        clk,
  input  wire        reset,
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        event_in,
  input  wire        companion_tick,
  output wire        irq,
  output reg         capture_event
);

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  // one wait state: request accepted on the second edge it is held
  reg        ack_q;
  wire       req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  wire       acc = req & ack_q;
  wire       wr  = acc & avs_write;
  wire       rd  = acc & avs_read;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg        enable_q;
  reg [1:0]  clk_sel_q;
  reg [2:0]  mode_q;
  reg        ev_en_q;
  reg        edge_q;
  reg        int_en_q;
  reg        flag_q;
  reg [15:0] count_q;
  reg [15:0] ccv_q;
  reg        run_q;
  reg        pw_fall_q;
  reg        armed_q;
  reg        wrap_q;
  reg        div_q;

  function sel;
    input [5:0] a;
    input [5:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  // ----------------------------------------
  // event input: three-stage sync, edge when stages 2 and 3 differ
  // ----------------------------------------
  reg  [2:0] ev_sync_q;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ev_sync_q <= 3'h0;
    end else begin
      ev_sync_q <= {ev_sync_q[1:0], event_in};
    end
  end
  // pulses shorter than a cycle may be lost here
  wire ev_rise = ev_sync_q[1] & ~ev_sync_q[2];
  wire ev_fall = ~ev_sync_q[1] & ev_sync_q[2];
  wire ev_ok   = enable_q & ev_en_q;
  wire ev_sel  = ev_ok & (edge_q ? ev_fall : ev_rise);
  wire ev_any  = ev_ok & (ev_rise | ev_fall);
  wire ev_r    = ev_ok & ev_rise;
  wire ev_f    = ev_ok & ev_fall;

  // ----------------------------------------
  // counting clock enable
  // ----------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      div_q <= 1'b0;
    end else begin
      div_q <= ~div_q;
    end
  end
  reg tick;
  always @* begin
    case (clk_sel_q)
      `CPT_CLK_DIV1: tick = 1'b1;
      `CPT_CLK_DIV2: tick = div_q;
      `CPT_CLK_COMP: tick = companion_tick;
      default:       tick = 1'b0;
    endcase
  end
  wire cnt_en = enable_q & tick;

  // ----------------------------------------
  // mode engine
  // ----------------------------------------
  wire at_top  = (count_q == ccv_q) & ~wrap_q;
  wire at_max  = (count_q == `CPT_MAX);
  wire [15:0] inc = count_q + 16'h0001;
  wire ccv_lo_rd = rd & sel(avs_address, `CPT_CCV_OFS) & avs_byteenable[0];
  wire cap_mode = (mode_q == `CPT_MODE_CAPEVT) | (mode_q == `CPT_MODE_FREQ) |
                  (mode_q == `CPT_MODE_PW) | (mode_q == `CPT_MODE_FRQPW);

  reg        set_flag;
  reg [15:0] count_d;
  reg [15:0] cap_d;
  reg        cap_we;
  reg        run_d;
  reg        pw_fall_d;
  reg        armed_d;

  always @* begin
    set_flag  = 1'b0;
    count_d   = count_q;
    cap_d     = count_q;
    cap_we    = 1'b0;
    run_d     = run_q;
    pw_fall_d = pw_fall_q;
    armed_d   = armed_q;
    case (mode_q)
      `CPT_MODE_PERIODIC: begin
        if (cnt_en) begin
          if (at_top) begin
            set_flag = 1'b1;
            count_d  = `CPT_BOTTOM;
          end else begin
            count_d = inc;
          end
        end
      end
      `CPT_MODE_TIMEOUT: begin
        if (ev_sel) begin
          run_d = ~run_q;
          if (!run_q) count_d = `CPT_BOTTOM;
        end else if (run_q && cnt_en) begin
          count_d = at_top ? `CPT_BOTTOM : inc;
          if (at_top) set_flag = 1'b1;
        end
      end
      `CPT_MODE_CAPEVT: begin
        if (cnt_en) count_d = inc;
        if (ev_sel) begin
          cap_we   = 1'b1;
          set_flag = 1'b1;
        end
      end
      `CPT_MODE_FREQ: begin
        if (ev_sel) begin
          cap_we   = 1'b1;
          set_flag = 1'b1;
          count_d  = `CPT_BOTTOM;
        end else if (cnt_en) begin
          count_d = inc;
        end
      end
      `CPT_MODE_PW: begin
        if (ev_r) begin
          count_d   = `CPT_BOTTOM;
          pw_fall_d = 1'b1;
        end else begin
          if (cnt_en) count_d = inc;
          if (ev_f && pw_fall_q) begin
            cap_we    = 1'b1;
            set_flag  = 1'b1;
            pw_fall_d = 1'b0;
          end
        end
      end
      `CPT_MODE_FRQPW: begin
        if (ev_r && armed_q && !run_q) begin
          count_d = `CPT_BOTTOM;
          run_d   = 1'b1;
          pw_fall_d = 1'b1;
        end else if (ev_r && run_q) begin
          run_d    = 1'b0;
          armed_d  = 1'b0;
          set_flag = 1'b1;
        end else begin
          if (run_q && cnt_en) count_d = inc;
          if (ev_f && run_q && pw_fall_q) begin
            cap_we    = 1'b1;
            pw_fall_d = 1'b0;
          end
        end
        // a read racing the stop edge must not rearm while the flag stays set
        if (ccv_lo_rd && !set_flag) armed_d = 1'b1;
      end
      default: begin
        if (cnt_en) count_d = inc;
      end
    endcase
  end

  // ----------------------------------------
  // state update and register writes
  // ----------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      enable_q      <= 1'b0;
      clk_sel_q     <= `CPT_CLK_DIV1;
      mode_q        <= `CPT_MODE_PERIODIC;
      ev_en_q       <= 1'b0;
      edge_q        <= 1'b0;
      int_en_q      <= 1'b0;
      flag_q        <= 1'b0;
      count_q       <= `CPT_BOTTOM;
      ccv_q         <= `CPT_CCV_RST;
      run_q         <= 1'b0;
      pw_fall_q     <= 1'b0;
      armed_q       <= 1'b1;
      wrap_q        <= 1'b0;
      capture_event <= 1'b0;
    end else begin
      count_q       <= count_d;
      run_q         <= run_d;
      pw_fall_q     <= pw_fall_d;
      armed_q       <= armed_d;
      capture_event <= set_flag;
      if (cap_we) ccv_q <= cap_d;
      // top moved below count: compare again only after the wrap
      if (count_d == `CPT_BOTTOM) begin
        wrap_q <= 1'b0;
      end else if (at_max && cnt_en) begin
        wrap_q <= 1'b0;
      end
      if (wr) begin
        if (sel(avs_address, `CPT_CTRLA_OFS) && avs_byteenable[0]) begin
          enable_q  <= avs_writedata[`CPT_CTRLA_EN];
          clk_sel_q <= avs_writedata[`CPT_CTRLA_CLK_HI:`CPT_CTRLA_CLK_LO];
        end else if (sel(avs_address, `CPT_CTRLB_OFS) && avs_byteenable[0]) begin
          mode_q <= avs_writedata[`CPT_MODE_HI:`CPT_MODE_LO];
        end else if (sel(avs_address, `CPT_EVCTRL_OFS) && avs_byteenable[0]) begin
          ev_en_q <= avs_writedata[`CPT_EV_INPUT_EN];
          edge_q  <= avs_writedata[`CPT_EV_EDGE];
        end else if (sel(avs_address, `CPT_INTCTRL_OFS) && avs_byteenable[0]) begin
          int_en_q <= avs_writedata[`CPT_FLAG_BIT];
        end else if (sel(avs_address, `CPT_STATUS_OFS) && avs_byteenable[0]) begin
          // run bit ignored whenever timeout mode is selected
          if (mode_q != `CPT_MODE_TIMEOUT) run_q <= avs_writedata[`CPT_STATUS_RUN];
        end else if (sel(avs_address, `CPT_COUNT_OFS)) begin
          if (avs_byteenable[0]) count_q[7:0]  <= avs_writedata[7:0];
          if (avs_byteenable[1]) count_q[15:8] <= avs_writedata[15:8];
        end else if (sel(avs_address, `CPT_CCV_OFS)) begin
          if (avs_byteenable[0]) ccv_q[7:0]  <= avs_writedata[7:0];
          if (avs_byteenable[1]) ccv_q[15:8] <= avs_writedata[15:8];
          if (mode_q == `CPT_MODE_PERIODIC || mode_q == `CPT_MODE_TIMEOUT) begin
            if ({avs_byteenable[1] ? avs_writedata[15:8] : ccv_q[15:8],
                 avs_byteenable[0] ? avs_writedata[7:0] : ccv_q[7:0]} < count_q)
              wrap_q <= 1'b1;
          end
        end
      end
      // set beats any clear in the same cycle
      if (set_flag) begin
        flag_q <= 1'b1;
      end else if (cap_mode && ccv_lo_rd) begin
        flag_q <= 1'b0;
      end else if (wr && sel(avs_address, `CPT_INTFLAGS_OFS) && avs_byteenable[0] &&
                   avs_writedata[`CPT_FLAG_BIT]) begin
        flag_q <= 1'b0;
      end
    end
  end

  assign irq = flag_q & int_en_q;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    if (sel(avs_address, `CPT_CTRLA_OFS)) begin
      rd_mux = {29'h0, clk_sel_q, enable_q};
    end else if (sel(avs_address, `CPT_CTRLB_OFS)) begin
      rd_mux = {29'h0, mode_q};
    end else if (sel(avs_address, `CPT_EVCTRL_OFS)) begin
      rd_mux = {27'h0, edge_q, 3'h0, ev_en_q};
    end else if (sel(avs_address, `CPT_INTCTRL_OFS)) begin
      rd_mux = {31'h0, int_en_q};
    end else if (sel(avs_address, `CPT_INTFLAGS_OFS)) begin
      rd_mux = {31'h0, flag_q};
    end else if (sel(avs_address, `CPT_STATUS_OFS)) begin
      rd_mux = {31'h0, run_q};
    end else if (sel(avs_address, `CPT_COUNT_OFS)) begin
      rd_mux = {16'h0, count_q};
    end else if (sel(avs_address, `CPT_CCV_OFS)) begin
      rd_mux = {16'h0, ccv_q};
    end
  end

  // captured in the wait cycle, so it stands through the accept cycle
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack_q) begin
      avs_readdata <= rd_mux;
    end
  end

endmodule

/* inc/cpt_defines.vh */
// capture timer constants: register offsets, field positions, reset values, mode codes
// assumes a 32-bit avalon-mm slave with word-aligned byte addresses
//
// Contract
// - 16-bit up-counter, wraps max to bottom
// - resets into periodic mode; six modes, codes 6 and 7 only free-run
// - clock select: prescaled or companion clock
// - periodic: flag at top, restart bottom
// - top below count: run to max first
// - timeout: start first edge, stop next
// - timeout: flag when top reached first
// - frozen after stop until new start
// - capture on event: free run, capture edge
// - capture modes: low byte read clears flag
// - frequency: capture and restart each edge
// - pulse width: restart rise, capture fall
// - combined: start rise, capture fall, stop rise
// - combined: low byte read rearms the sequence
// - irq while flag and enable set
// - capture event pulse equals flag set
`ifndef CPT_DEFINES_VH
`define CPT_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CPT_CTRLA_OFS     6'h00
`define CPT_CTRLB_OFS     6'h04
`define CPT_EVCTRL_OFS    6'h08
`define CPT_INTCTRL_OFS   6'h0C
`define CPT_INTFLAGS_OFS  6'h10
`define CPT_STATUS_OFS    6'h14
`define CPT_COUNT_OFS     6'h18
`define CPT_CCV_OFS       6'h1C

// ----------------------------------------
// field positions
// ----------------------------------------
`define CPT_CTRLA_EN      0
`define CPT_CTRLA_CLK_LO  1
`define CPT_CTRLA_CLK_HI  2
`define CPT_EV_INPUT_EN   0
`define CPT_EV_EDGE       4
`define CPT_FLAG_BIT      0
`define CPT_STATUS_RUN    0
`define CPT_MODE_LO       0
`define CPT_MODE_HI       2

// ----------------------------------------
// clock sources and modes
// ----------------------------------------
`define CPT_CLK_DIV1      2'h0
`define CPT_CLK_DIV2      2'h1
`define CPT_CLK_COMP      2'h2
`define CPT_MODE_PERIODIC 3'h0
`define CPT_MODE_TIMEOUT  3'h1
`define CPT_MODE_CAPEVT   3'h2
`define CPT_MODE_FREQ     3'h3
`define CPT_MODE_PW       3'h4
`define CPT_MODE_FRQPW    3'h5
`define CPT_MODE_SINGLE   3'h6
`define CPT_MODE_PWM8     3'h7

// ----------------------------------------
// reset values and counter maximum
// ----------------------------------------
`define CPT_BOTTOM        16'h0000
`define CPT_MAX           16'hFFFF
`define CPT_CCV_RST       16'h0000

`endif

/* verification/cpt_evt_src.sv */
// event router stand-in: one pulse per request, held a set number of cycles
// assumes requests come from the bench on the peripheral clock
`timescale 1ns/1ps
module cpt_evt_src (
  input  wire       clk,
  input  wire       reset,
  input  wire       go,
  input  wire [7:0] hi_cyc,
  output reg        event_in
);
  reg [7:0] left_q;
  // never shorter than two cycles, so each edge survives the synchroniser
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      left_q   <= 8'h00;
      event_in <= 1'b0;
    end else if (go) begin
      left_q   <= (hi_cyc < 8'h02) ? 8'h02 : hi_cyc;
      event_in <= 1'b1;
    end else if (left_q != 8'h00) begin
      left_q   <= left_q - 8'h01;
      event_in <= (left_q != 8'h01);
    end
  end
endmodule

/* verification/cpt_capture_timer_properties.sv */
// checker for the capture timer top: bus handshake, irq, capture event
// assumes one clock, async active-high reset, master holds each request
`timescale 1ns/1ps
module cpt_chk (
  input wire        clk,
  input wire        reset,
  input wire [5:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        irq,
  input wire        capture_event
);
  wire req = avs_read | avs_write;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ------
  // properties
  // ------
  sequence s_wait; req && avs_waitrequest; endsequence
  sequence s_take; req && !avs_waitrequest; endsequence
  property p_wait_first; $rose(req) |-> avs_waitrequest; endproperty
  property p_one_wait; s_wait |=> s_take; endproperty
  property p_wait_again; s_take |=> avs_waitrequest || !req; endproperty
  property p_unmapped; s_take ##0 avs_read && avs_address > 6'h1C |-> avs_readdata == 32'h0;
  endproperty
  property p_irq_fall; $fell(irq) |-> $past(req); endproperty
  property p_irq_hold; irq && !req |=> irq; endproperty
  // an enable write may raise irq on an old flag, so it is excluded
  property p_irq_cause; $rose(irq) && !$past(avs_write) |-> ##[0:1] capture_event;
  endproperty
  property p_evt_pulse; capture_event |=> !capture_event; endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait at request start");
  a_one_wait: assert property (p_one_wait) else $error("wait state not one cycle");
  a_wait_again: assert property (p_wait_again) else $error("accept held two cycles");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without access");
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped while idle");
  a_irq_cause: assert property (p_irq_cause) else $error("irq without event");
  a_evt_pulse: assert property (p_evt_pulse) else $error("event pulse too long");
endmodule
bind cpt_capture_timer cpt_chk u_chk (.clk(clk), .reset(reset), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq), .capture_event(capture_event));

/* verification/cpt_capture_timer_tb.sv */
// bench for the capture timer: periodic table, then event-driven modes
// assumes the event source model and a one-wait-state register bus
`timescale 1ns/1ps
`include "cpt_defines.vh"
`define CK(g, e) begin n_compared = n_compared + 1; if ((g) !== (e)) begin \
  num_errors = num_errors + 1; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module cpt_capture_timer_tb;
  reg         clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  reg         go = 1'b0, companion_tick = 1'b0;
  reg  [5:0]  avs_address = 6'h00;
  reg  [31:0] avs_writedata = 32'h0, q, c1;
  reg  [7:0]  hi = 8'h00;
  reg  [3:0]  be = 4'hF;
  reg  [25:0] rows [0:2];
  wire [31:0] avs_readdata;
  wire        avs_waitrequest, event_in, irq, capture_event;
  integer     num_errors = 0, n_compared = 0, cyc = 0, n, t, i;
  cpt_capture_timer dut (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(be), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .event_in(event_in), .companion_tick(companion_tick), .irq(irq),
    .capture_event(capture_event));
  cpt_evt_src u_src (.clk(clk), .reset(reset), .go(go), .hi_cyc(hi), .event_in(event_in));
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    companion_tick <= (cyc[1:0] == 2'h3);
  end
  // ------
  // tasks
  // ------
  task bus(input w, input [5:0] a, input [31:0] d);
    integer k;
    begin
      k = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do begin
        @(posedge clk);
        k = k + 1;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (k >= 50) num_errors = num_errors + 1;
      @(posedge clk);
    end
  endtask
  task wev;
    begin
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
      end while (capture_event !== 1'b1 && n < 2000);
      if (n >= 2000) num_errors = num_errors + 1;
    end
  endtask
  task ev(input integer at, input [7:0] w);
    begin
      while (cyc < at) @(posedge clk);
      go <= 1'b1;
      hi <= w;
      @(posedge clk);
      go <= 1'b0;
    end
  endtask
  task mode(input [2:0] m, input [7:0] e);
    begin
      bus(1'b1, `CPT_CTRLA_OFS, 32'h0);
      bus(1'b1, `CPT_CTRLB_OFS, {29'h0, m});
      bus(1'b1, `CPT_EVCTRL_OFS, {24'h0, e});
      bus(1'b1, `CPT_INTFLAGS_OFS, 32'h1);
      bus(1'b1, `CPT_COUNT_OFS, 32'h0);
      bus(1'b1, `CPT_CTRLA_OFS, 32'h1);
    end
  endtask
  // two captures a fixed gap apart; c1 and q hold them
  task pair(input integer at, input [7:0] w1, input integer g, input [7:0] w2);
    begin
      ev(at, w1);
      wev;
      bus(1'b0, `CPT_CCV_OFS, 32'h0);
      c1 = q;
      `CK(irq, 1'b0)
      ev(at + g, w2);
      wev;
      bus(1'b0, `CPT_CCV_OFS, 32'h0);
    end
  endtask
  task close_out;
    begin
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    num_errors = num_errors + 1;
    close_out;
  end
  // ------
  // scenarios
  // ------
  initial begin
    rows[0] = {2'h0, 16'h0005, 8'h06};
    rows[1] = {2'h1, 16'h0005, 8'h0C};
    rows[2] = {2'h2, 16'h0002, 8'h0C};
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 9; i = i + 1) begin
      bus(1'b0, {i[3:0], 2'h0}, 32'h0);
      `CK(q, 32'h0)
    end
    bus(1'b1, `CPT_INTCTRL_OFS, 32'h1);
    for (i = 0; i < 3; i = i + 1) begin
      bus(1'b1, `CPT_CTRLA_OFS, 32'h0);
      bus(1'b1, `CPT_COUNT_OFS, 32'h0);
      bus(1'b1, `CPT_INTFLAGS_OFS, 32'h1);
      `CK(irq, 1'b0)
      bus(1'b1, `CPT_CCV_OFS, {16'h0, rows[i][23:8]});
      bus(1'b1, `CPT_CTRLA_OFS, {29'h0, rows[i][25:24], 1'b1});
      wev;
      wev;
      `CK(n[7:0], rows[i][7:0])
      `CK(irq, 1'b1)
    end
    bus(1'b1, `CPT_CTRLA_OFS, 32'h0);
    bus(1'b1, `CPT_COUNT_OFS, 32'h0000FFF0);
    repeat (10) @(posedge clk);
    bus(1'b0, `CPT_COUNT_OFS, 32'h0);
    `CK(q[15:0], 16'hFFF0)
    // enabled with the stopped clock source: no ticks
    bus(1'b1, `CPT_CTRLA_OFS, 32'h7);
    repeat (10) @(posedge clk);
    bus(1'b0, `CPT_COUNT_OFS, 32'h0);
    `CK(q[15:0], 16'hFFF0)
    bus(1'b1, `CPT_CCV_OFS, 32'h5);
    bus(1'b1, `CPT_CTRLA_OFS, 32'h1);
    wev;
    `CK(n > 19 && n < 24, 1'b1)
    bus(1'b1, `CPT_CCV_OFS, 32'h1E);
    mode(`CPT_MODE_TIMEOUT, 8'h01);
    repeat (50) @(posedge clk);
    ev(cyc, 8'h04);
    wev;
    `CK(n > 27 && n < 41, 1'b1)
    bus(1'b1, `CPT_INTFLAGS_OFS, 32'h1);
    `CK(irq, 1'b0)
    ev(cyc, 8'h04);
    repeat (10) @(posedge clk);
    bus(1'b0, `CPT_COUNT_OFS, 32'h0);
    c1 = q;
    bus(1'b1, `CPT_STATUS_OFS, 32'h1);
    repeat (20) @(posedge clk);
    bus(1'b0, `CPT_COUNT_OFS, 32'h0);
    `CK(q, c1)
    t = cyc;
    ev(t, 8'h04);
    ev(t + 8, 8'h04);
    repeat (60) @(posedge clk);
    `CK(irq, 1'b0)
    mode(`CPT_MODE_CAPEVT, 8'h01);
    pair(cyc, 8'h04, 100, 8'h04);
    `CK(q[15:0] - c1[15:0], 16'h0064)
    mode(`CPT_MODE_FREQ, 8'h11);
    t = cyc;
    ev(t, 8'h04);
    pair(t + 53, 8'h04, 60, 8'h04);
    `CK(q[15:0] - c1[15:0], 16'h0007)
    mode(`CPT_MODE_PW, 8'h01);
    pair(cyc, 8'h0A, 50, 8'h0F);
    `CK(q[15:0] - c1[15:0], 16'h0005)
    mode(`CPT_MODE_FRQPW, 8'h01);
    t = cyc;
    ev(t, 8'h0A);
    repeat (20) @(posedge clk);
    `CK(irq, 1'b0)
    ev(t + 40, 8'h0A);
    wev;
    `CK(irq, 1'b1)
    // high byte alone must leave the flag set
    be <= 4'h2;
    bus(1'b0, `CPT_CCV_OFS, 32'h0);
    be <= 4'hF;
    `CK(irq, 1'b1)
    bus(1'b0, `CPT_CCV_OFS, 32'h0);
    `CK(irq, 1'b0)
    // second reset in mid-run: mode must fall back to periodic
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    bus(1'b0, `CPT_CTRLB_OFS, 32'h0);
    `CK(q, 32'h0)
    close_out;
  end
endmodule
